// [testbench/amhw_sensor_model.sv]
`timescale 1ns/10ps
`default_nettype none
// ======================================================
// far-side sensors: levels arrive off the clock grid
module amhw_sensor_model #(
   parameter int SETTLE_NS = 7
) (
   input wire logic hall_lvl,
   input wire logic cur_lvl,
   input wire logic ovc_lvl,
   input wire logic wake_lvl,
   output wire logic hall_pin,
   output wire logic cur_below,
   output wire logic overcur,
   output wire logic wake_pin
);
   // odd delay keeps pin edges away from the sampling edge
   assign #(SETTLE_NS) hall_pin = hall_lvl;
   assign #(SETTLE_NS) cur_below = cur_lvl;
   assign #(SETTLE_NS) overcur = ovc_lvl;
   assign #(SETTLE_NS) wake_pin = wake_lvl;
endmodule
`default_nettype wire

// [testbench/testbench.sv]
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic clk, nrst, addr, wr, power_stage_on, stp, slp;
   logic hien, hclr, wien, wclr, wfclr, hl, cl, ol, wl, v, mb;
   logic [7:0] wdata, rdata, d, r;
   logic [3:0] msel;
   logic [1:0] lvl;
   logic mval, gain, a0on, refon, hsup, hsen, hpu;
   logic hif, hirq, wif, wirq, wreq, wwf;
   wire logic hp, cb, oc, wp;
   logic [31:0] seed;
   int error_cnt, check_count, i, j, m;
   // ======================================================
   // design and sensors
   amhw_ctrl uut (.SYS_CLK(clk), .NRST(nrst), .REG_ADDR(addr),
      .REG_WR(wr), .REG_WDATA(wdata), .REG_RDATA(rdata),
      .POWER_STAGE_ON(power_stage_on), .STOP_MODE(stp), .SLEEP_MODE(slp),
      .HALL_PIN(hp), .HALL_CUR_BELOW(cb), .HALL_OVERCUR(oc),
      .WAKE_IN_PIN(wp), .HALL_IRQ_EN(hien), .HALL_IRQ_CLR(hclr),
      .WAKE_IN_IRQ_EN(wien), .WAKE_IN_IRQ_CLR(wclr),
      .WAKEFLAG_CLR(wfclr), .MUX_SEL(msel), .MUX_VALID(mval),
      .SENSE_GAIN_SEL(gain), .ISRC_LEVEL(lvl), .ISRC_AIN_ON(a0on),
      .ISRC_REF_ON(refon), .HALL_SUPPLY_ON(hsup), .HALL_SENSE_ON(hsen),
      .HALL_PULLUP_ON(hpu), .HALL_IRQ_FLAG(hif), .HALL_IRQ(hirq),
      .WAKE_IN_IRQ_FLAG(wif), .WAKE_IN_IRQ(wirq), .WAKE_REQ(wreq),
      .WAKE_IN_WAKEFLAG(wwf));
   amhw_sensor_model sens (.hall_lvl(hl), .cur_lvl(cl), .ovc_lvl(ol),
      .wake_lvl(wl), .hall_pin(hp), .cur_below(cb), .overcur(oc),
      .wake_pin(wp));
   // ======================================================
   // helpers
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   function automatic void rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
   endfunction
   // all drives land 2 ns after the rising edge
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      cyc(1);
      s = 1'b0;
      cyc(1);
   endtask
   task automatic wreg(input logic a, input logic [7:0] x);
      addr = a;
      wdata = x;
      wr = 1'b1;
      cyc(1);
      wr = 1'b0;
   endtask
   task automatic rreg(input logic a, output logic [7:0] x);
      addr = a;
      cyc(1);
      x = rdata;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   function automatic logic valid_src(input logic [3:0] c);
      return !(c == 4'h7 || c >= 4'hC);
   endfunction
   function automatic logic src_on(input logic [7:0] x, input logic [3:0] c);
      return x[7] & power_stage_on & !stp & !slp & (x[3:0] == c);
   endfunction
   task automatic close_out();
      if (error_cnt == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      close_out();
   end
   // ======================================================
   // main sequence
   initial begin
      {nrst, addr, wr, wdata, power_stage_on, stp, slp} = '0;
      {hien, hclr, wien, wclr, wfclr, hl, cl, ol, wl, v} = '0;
      seed = 32'hF24F;
      error_cnt = 0;
      check_count = 0;
      cyc(20);
      nrst = 1'b1;
      rreg(1'b0, r);
      chk(r, 8'h00);
      rreg(1'b1, r);
      chk(r, 8'h00);
      chk(hpu, 1'b1);
      chk(mval, 1'b1);
      // every source code twice, level/gain/enable random
      for (i = 0; i < 32; i++) begin
         rnd();
         power_stage_on = seed[8];
         stp = seed[9] & seed[10];
         slp = seed[11] & seed[12];
         d = {seed[3:0], i[3:0]};
         if (i == 10 || i == 11) {d[7], power_stage_on, stp, slp} = 4'b1100;
         if (i == 26) {d[7], power_stage_on, stp, slp} = 4'b1110;
         if (i == 27) {d[7], power_stage_on, stp, slp} = 4'b1101;
         wreg(1'b0, d);
         cyc(2);
         rreg(1'b0, r);
         chk(r, d);
         chk(msel, d[3:0]);
         chk(mval, valid_src(d[3:0]));
         chk(lvl, d[6:5]);
         chk(gain, d[4]);
         chk(a0on, src_on(d, 4'hA));
         chk(refon, src_on(d, 4'hB));
      end
      {stp, slp} = 2'b00;
      // hall: general purpose then two-pin; state pins disagree
      for (m = 0; m < 2; m++) begin
         mb = m[0];
         // pre-set pins so the first toggle below is a real state edge
         {hl, cl} = mb ? {!v, v} : {v, !v};
         wreg(1'b1, {5'b11101, mb, !mb, mb});
         cyc(2);
         rreg(1'b1, r);
         chk(r & 8'hC7, {5'b0, mb, !mb, mb});
         chk(hsup, mb);
         chk(hsen, mb);
         chk(hpu, 1'b0);
         if (mb) cyc(1600);
         ol = 1'b1;
         cyc(8);
         ol = 1'b0;
         cyc(8);
         wreg(1'b1, {5'b00000, mb, !mb, mb});
         rreg(1'b1, r);
         chk(r[4], mb);
         wreg(1'b1, {5'b00010, mb, !mb, mb});
         rreg(1'b1, r);
         chk(r[4], 1'b0);
         pulse(hclr);
         for (j = 0; j < 4; j++) begin
            rnd();
            hien = seed[0];
            v = !v;
            {hl, cl} = mb ? {!v, v} : {v, !v};
            cyc(10);
            rreg(1'b1, r);
            chk(r[3], v);
            chk(hif, 1'b1);
            chk(hirq, hien);
            pulse(hclr);
            cyc(10);
            chk(hif, 1'b0);
         end
      end
      // no hall flag in stop mode
      stp = 1'b1;
      v = !v;
      {hl, cl} = {!v, v};
      cyc(10);
      chk(hif, 1'b0);
      stp = 1'b0;
      cyc(10);
      pulse(hclr);
      // wake input in run, then stop and sleep
      for (j = 0; j < 2; j++) begin
         rnd();
         wien = seed[0];
         wl = !wl;
         cyc(10);
         rreg(1'b1, r);
         chk(r[5], wl);
         chk(wif, 1'b1);
         chk(wirq, wien);
         pulse(wclr);
      end
      for (j = 0; j < 2; j++) begin
         {stp, slp} = j[0] ? 2'b01 : 2'b10;
         cyc(4);
         chk(wreq, 1'b0);
         wl = !wl;
         cyc(10);
         chk(wreq, 1'b1);
         chk(wwf, j[0]);
         {stp, slp} = 2'b00;
         cyc(4);
         chk(wreq, 1'b0);
         pulse(wfclr);
         pulse(wclr);
         chk(wwf, 1'b0);
      end
      // mid-run reset with over-current pending
      ol = 1'b1;
      cyc(8);
      ol = 1'b0;
      cyc(8);
      nrst = 1'b0;
      cyc(2);
      nrst = 1'b1;
      rreg(1'b0, r);
      chk(r, 8'h00);
      rreg(1'b1, r);
      chk(r & 8'hD7, 8'h00);
      chk(hpu, 1'b1);
      close_out();
   end
endmodule
`default_nettype wire

// [verilog/amhw_ctrl.sv]
// Function
// - 4-bit select routes HB1-4 sense (0-3), HS1-3 sense (4-6) to output
// - codes 8-11 temp, supply, analog pin, reference; 7, 12-15 unused
// - current source drives only with power stage, selection and enable
// - 2-bit level field picks 40, 120, 320 uA or highest level
// - current source off in STOP or SLEEP regardless of enable
// - gain select 1 low, 0 high amplification for half-bridge sense
// - reset clears enable, level, gain and source select
// - mode bit set gives two-pin hall input, clear gives plain input
// - two-pin mode with enable switches supply on and sense circuitry
// - hall state 0 for high current or low pin, else 1
// - two-pin over-current sets flag; write 1 clears; reset clears
// - plain input mode pull-up follows disable bit; on after reset
// - RUN-only hall state change sets hall irq flag; mask gates request
// - wake state flag reflects wake-up input level
// - in RUN both wake input edges raise irq when enabled
// - wake level stored on low-power entry; change then starts wake-up
// - wake from SLEEP by wake input sets wakeflag; write 1 clears
// - reset clears hall enable, pull-up disable and hall mode
`timescale 1ns/10ps
`default_nettype none
`include "amhw_map.svh"
module amhw_ctrl (
   input wire logic SYS_CLK,
   input wire logic NRST,
   input wire logic REG_ADDR,
   input wire logic REG_WR,
   input wire logic [7:0] REG_WDATA,
   output var logic [7:0] REG_RDATA,
   input wire logic POWER_STAGE_ON,
   input wire logic STOP_MODE,
   input wire logic SLEEP_MODE,
   input wire logic HALL_PIN,
   input wire logic HALL_CUR_BELOW,
   input wire logic HALL_OVERCUR,
   input wire logic WAKE_IN_PIN,
   input wire logic HALL_IRQ_EN,
   input wire logic HALL_IRQ_CLR,
   input wire logic WAKE_IN_IRQ_EN,
   input wire logic WAKE_IN_IRQ_CLR,
   input wire logic WAKEFLAG_CLR,
   output var logic [3:0] MUX_SEL,
   output var logic MUX_VALID,
   output var logic SENSE_GAIN_SEL,
   output var logic [1:0] ISRC_LEVEL,
   output var logic ISRC_AIN_ON,
   output var logic ISRC_REF_ON,
   output var logic HALL_SUPPLY_ON,
   output var logic HALL_SENSE_ON,
   output var logic HALL_PULLUP_ON,
   output var logic HALL_IRQ_FLAG,
   output var logic HALL_IRQ,
   output var logic WAKE_IN_IRQ_FLAG,
   output var logic WAKE_IN_IRQ,
   output var logic WAKE_REQ,
   output var logic WAKE_IN_WAKEFLAG
);
   amhw_pkg::amhw_byte_t asel_q;
   amhw_pkg::amhw_mode_e mode_q;
   logic hall_mode_q, hall_en_q, hall_pd_q, hall_oc_q;
   logic hall_state_q, hall_prev_q, hall_flag_q;
   logic wake_prev_q, wake_flag_q, wake_store_q, lp_prev_q, wakeflag_q;
   logic hall_flag_d, wake_flag_d, wake_req_d, lp_w, sel_valid_w;
   logic wr_asel, wr_hls;
   logic [3:0] sel_w;
   logic [`AMHW_SYNC_W-1:0] pin_raw, pin_s;

   // ======================================================
   // input synchronisation
   assign pin_raw = {WAKE_IN_PIN, HALL_OVERCUR, HALL_CUR_BELOW, HALL_PIN};
   amhw_sync u_sync (
      .clk(SYS_CLK),
      .nrst(NRST),
      .din(pin_raw),
      .dout(pin_s)
   );

   // ======================================================
   // register writes
   assign wr_asel = REG_WR && (REG_ADDR == `AMHW_ADDR_ASEL);
   assign wr_hls = REG_WR && (REG_ADDR == `AMHW_ADDR_HLS);
   assign sel_w = asel_q[`AMHW_SEL_HI:`AMHW_SEL_LO];

   always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
         asel_q <= `AMHW_ASEL_RST;
      end else if (wr_asel) begin
         asel_q <= REG_WDATA;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
         hall_mode_q <= 1'b0;
         hall_en_q <= 1'b0;
         hall_pd_q <= 1'b0;
      end else if (wr_hls) begin
         hall_mode_q <= REG_WDATA[`AMHW_HMS_BIT];
         hall_en_q <= REG_WDATA[`AMHW_HEN_BIT];
         hall_pd_q <= REG_WDATA[`AMHW_HPD_BIT];
      end
   end

   // set beats a same-cycle write-one clear
   always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
         hall_oc_q <= 1'b0;
      end else if (hall_mode_q && pin_s[`AMHW_SI_HOC]) begin
         hall_oc_q <= 1'b1;
      end else if (wr_hls && REG_WDATA[`AMHW_HOC_BIT]) begin
         hall_oc_q <= 1'b0;
      end
   end

   // ======================================================
   // power mode tracking
   always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
         mode_q <= amhw_pkg::MODE_RUN;
      end else if (SLEEP_MODE) begin
         mode_q <= amhw_pkg::MODE_SLEEP;
      end else if (STOP_MODE) begin
         mode_q <= amhw_pkg::MODE_STOP;
      end else begin
         mode_q <= amhw_pkg::MODE_RUN;
      end
   end

   always_comb begin
      case (mode_q)
         amhw_pkg::MODE_RUN: lp_w = 1'b0;
         default: lp_w = 1'b1;
      endcase
   end

   always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
         lp_prev_q <= 1'b0;
      end else begin
         lp_prev_q <= lp_w;
      end
   end

   // ======================================================
   // analog select outputs
   assign sel_valid_w = (sel_w <= `AMHW_SRC_HS3) ||
      ((sel_w >= `AMHW_SRC_TEMP) && (sel_w <= `AMHW_SRC_REF));

   always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
         MUX_SEL <= 4'h0;
         MUX_VALID <= 1'b1;
         SENSE_GAIN_SEL <= 1'b0;
         ISRC_LEVEL <= 2'h0;
         ISRC_AIN_ON <= 1'b0;
         ISRC_REF_ON <= 1'b0;
      end else begin
         MUX_SEL <= sel_w;
         MUX_VALID <= sel_valid_w;
         SENSE_GAIN_SEL <= asel_q[`AMHW_GAIN_BIT];
         ISRC_LEVEL <= asel_q[`AMHW_LVL_HI:`AMHW_LVL_LO];
         // gating is late in the path, but the source drops one cycle after mode_q leaves RUN
         ISRC_AIN_ON <= POWER_STAGE_ON && asel_q[`AMHW_ISRC_ON_BIT] &&
            (sel_w == `AMHW_SRC_AIN) && !lp_w;
         ISRC_REF_ON <= POWER_STAGE_ON && asel_q[`AMHW_ISRC_ON_BIT] &&
            (sel_w == `AMHW_SRC_REF) && !lp_w;
      end
   end

   // ======================================================
   // hall input
   always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
         HALL_SUPPLY_ON <= 1'b0;
         HALL_SENSE_ON <= 1'b0;
         HALL_PULLUP_ON <= 1'b1;
         hall_state_q <= 1'b0;
         hall_prev_q <= 1'b0;
      end else begin
         HALL_SUPPLY_ON <= hall_mode_q && hall_en_q;
         HALL_SENSE_ON <= hall_mode_q && hall_en_q;
         HALL_PULLUP_ON <= !hall_mode_q && !hall_pd_q;
         hall_state_q <= hall_mode_q ? pin_s[`AMHW_SI_HCUR] :
            pin_s[`AMHW_SI_HGP];
         hall_prev_q <= hall_state_q;
      end
   end

   // flag edges after a mode switch are real state changes too
   always_comb begin
      hall_flag_d = hall_flag_q && !HALL_IRQ_CLR;
      if ((hall_state_q != hall_prev_q) && !lp_w) begin
         hall_flag_d = 1'b1;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
         hall_flag_q <= 1'b0;
         HALL_IRQ_FLAG <= 1'b0;
         HALL_IRQ <= 1'b0;
      end else begin
         hall_flag_q <= hall_flag_d;
         HALL_IRQ_FLAG <= hall_flag_d;
         HALL_IRQ <= hall_flag_d && HALL_IRQ_EN;
      end
   end

   // ======================================================
   // wake-up input
   always_comb begin
      wake_flag_d = wake_flag_q && !WAKE_IN_IRQ_CLR;
      if ((pin_s[`AMHW_SI_WAKE] != wake_prev_q) && !lp_w) begin
         wake_flag_d = 1'b1;
      end
   end

   // stored level is valid one cycle after entry, hence lp_prev_q
   assign wake_req_d = lp_w && lp_prev_q &&
      (pin_s[`AMHW_SI_WAKE] != wake_store_q);

   always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
         wake_store_q <= 1'b0;
      end else if (lp_w && !lp_prev_q) begin
         wake_store_q <= pin_s[`AMHW_SI_WAKE];
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
         wake_prev_q <= 1'b0;
         wake_flag_q <= 1'b0;
         WAKE_IN_IRQ_FLAG <= 1'b0;
         WAKE_IN_IRQ <= 1'b0;
         WAKE_REQ <= 1'b0;
      end else begin
         wake_prev_q <= pin_s[`AMHW_SI_WAKE];
         wake_flag_q <= wake_flag_d;
         WAKE_IN_IRQ_FLAG <= wake_flag_d;
         WAKE_IN_IRQ <= wake_flag_d && WAKE_IN_IRQ_EN;
         WAKE_REQ <= wake_req_d;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
         wakeflag_q <= 1'b0;
      end else if (wake_req_d && (mode_q == amhw_pkg::MODE_SLEEP)) begin
         wakeflag_q <= 1'b1;
      end else if (WAKEFLAG_CLR) begin
         wakeflag_q <= 1'b0;
      end
   end
   assign WAKE_IN_WAKEFLAG = wakeflag_q;

   // ======================================================
   // read data, one cycle behind the address
   always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
         REG_RDATA <= `AMHW_BYTE_ZERO;
      end else if (REG_ADDR == `AMHW_ADDR_ASEL) begin
         REG_RDATA <= asel_q;
      end else begin
         REG_RDATA <= `AMHW_BYTE_ZERO;
         REG_RDATA[`AMHW_WAKE_ST_BIT] <= pin_s[`AMHW_SI_WAKE];
         REG_RDATA[`AMHW_HOC_BIT] <= hall_oc_q;
         REG_RDATA[`AMHW_HST_BIT] <= hall_state_q;
         REG_RDATA[`AMHW_HEN_BIT] <= hall_en_q;
         REG_RDATA[`AMHW_HPD_BIT] <= hall_pd_q;
         REG_RDATA[`AMHW_HMS_BIT] <= hall_mode_q;
      end
   end

   // ======================================================
   // checks
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!NRST);

   sequence s_lp_entry;
      !lp_w ##1 lp_w;
   endsequence

   sequence s_asel_wr_unused;
      wr_asel && (REG_WDATA[`AMHW_SEL_HI:`AMHW_SEL_LO] == `AMHW_SRC_UNUSED);
   endsequence

   a_isrc_gate: assert property (ISRC_AIN_ON |->
      $past(POWER_STAGE_ON) && $past(sel_w) == `AMHW_SRC_AIN)
      else $error("source drives without its enables");
   a_isrc_lowpwr: assert property (lp_w && $past(lp_w) |->
      !ISRC_AIN_ON && !ISRC_REF_ON)
      else $error("source drives in low power");
   a_mux_unused: assert property (s_asel_wr_unused |=> ##1
      !MUX_VALID && MUX_SEL == `AMHW_SRC_UNUSED)
      else $error("unused code reported valid");
   a_rst_asel: assert property ($rose(NRST) |->
      asel_q == `AMHW_ASEL_RST && HALL_PULLUP_ON)
      else $error("reset values wrong");
   a_ovc_set: assert property (hall_mode_q && pin_s[`AMHW_SI_HOC]
      |=> hall_oc_q)
      else $error("over-current not flagged");
   a_ovc_clear: assert property (hall_oc_q && wr_hls &&
      REG_WDATA[`AMHW_HOC_BIT] && !(hall_mode_q && pin_s[`AMHW_SI_HOC])
      |=> !hall_oc_q)
      else $error("over-current flag not cleared");
   a_hall_run: assert property ($rose(hall_flag_q) |->
      $past(!lp_w) && $past(hall_state_q != hall_prev_q))
      else $error("hall flag set outside run");
   a_wake_store: assert property (s_lp_entry |=>
      wake_store_q == $past(pin_s[`AMHW_SI_WAKE]))
      else $error("wake level not stored");
   a_wake_sleep: assert property ($rose(wakeflag_q) |->
      $past(mode_q) == amhw_pkg::MODE_SLEEP && WAKE_REQ)
      else $error("wakeflag set outside sleep wake");
   a_hall_supply: assert property (wr_hls && REG_WDATA[`AMHW_HMS_BIT]
      && REG_WDATA[`AMHW_HEN_BIT] |=> ##1 HALL_SUPPLY_ON)
      else $error("hall supply not on");
endmodule
`default_nettype wire

// [verilog/amhw_map.svh]
`ifndef AMHW_MAP_SVH
`define AMHW_MAP_SVH
// ======================================================
// register selects and reset values
`define AMHW_ADDR_ASEL 1'h0
`define AMHW_ADDR_HLS 1'h1
`define AMHW_ASEL_RST 8'h00
`define AMHW_HLS_RST 8'h00
`define AMHW_BYTE_ZERO 8'h00
// ======================================================
// analog_select_ctrl fields
`define AMHW_ISRC_ON_BIT 7
`define AMHW_LVL_HI 6
`define AMHW_LVL_LO 5
`define AMHW_GAIN_BIT 4
`define AMHW_SEL_HI 3
`define AMHW_SEL_LO 0
// ======================================================
// hall_wake_status_ctrl fields
`define AMHW_WAKE_ST_BIT 5
`define AMHW_HOC_BIT 4
`define AMHW_HST_BIT 3
`define AMHW_HEN_BIT 2
`define AMHW_HPD_BIT 1
`define AMHW_HMS_BIT 0
// ======================================================
// source select codes
`define AMHW_SRC_HS3 4'h6
`define AMHW_SRC_UNUSED 4'h7
`define AMHW_SRC_TEMP 4'h8
`define AMHW_SRC_AIN 4'hA
`define AMHW_SRC_REF 4'hB
// ======================================================
// synchroniser lanes
`define AMHW_SYNC_W 4
`define AMHW_SI_HGP 0
`define AMHW_SI_HCUR 1
`define AMHW_SI_HOC 2
`define AMHW_SI_WAKE 3
`endif

// [verilog/amhw_pkg.sv]
`default_nettype none
package amhw_pkg;
   typedef logic [7:0] amhw_byte_t;
   typedef enum logic [1:0] {
      MODE_RUN,
      MODE_STOP,
      MODE_SLEEP
   } amhw_mode_e;
endpackage
`default_nettype wire

// [verilog/amhw_sync.sv]
`timescale 1ns/10ps
`default_nettype none
`include "amhw_map.svh"
module amhw_sync (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [`AMHW_SYNC_W-1:0] din,
   output var logic [`AMHW_SYNC_W-1:0] dout
);
   logic [`AMHW_SYNC_W-1:0] st1_q;
   logic [`AMHW_SYNC_W-1:0] st2_q;
   logic [`AMHW_SYNC_W-1:0] st3_q;
   // ======================================================
   // three stages per lane; level accepted once stage 2 and 3 agree
   genvar i;
   generate
      for (i = 0; i < `AMHW_SYNC_W; i = i + 1) begin : g_lane
         always_ff @(posedge clk) begin
            if (!nrst) begin
               st1_q[i] <= 1'b0;
               st2_q[i] <= 1'b0;
               st3_q[i] <= 1'b0;
               dout[i] <= 1'b0;
            end else begin
               st1_q[i] <= din[i];
               st2_q[i] <= st1_q[i];
               st3_q[i] <= st2_q[i];
               if (st2_q[i] == st3_q[i]) begin
                  dout[i] <= st3_q[i];
               end
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire
